// ---- design/pmp_pkg.sv ----
// constants shared by the pulse stretcher block
package pmp_pkg;
   // clock and time base
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned DIV_W = 16;
   // per channel countdown, counted in milliseconds
   localparam int unsigned CNT_W = 25;
   localparam logic [24:0] MS_PER_S = 25'h00003e8;
   localparam logic [24:0] MS_PER_MIN = 25'h000ea60;
   localparam logic [24:0] OCT_STEP_MS = 25'h000000a;
   // setting ranges and reset values
   localparam logic [24:0] MS_LEN_MAX = 25'h000ea60;
   localparam logic [24:0] SEC_LEN_MAX = 25'h000012c;
   localparam logic [24:0] MIN_LEN_MAX = 25'h000012c;
   localparam logic [24:0] OCT_LEN_MAX = 25'h0057e40;
   localparam logic [15:0] MS_LEN_RST = 16'h0096;
   localparam logic [8:0] SEC_LEN_RST = 9'h000;
   localparam logic [8:0] MIN_LEN_RST = 9'h000;
   localparam logic [18:0] OCT_LEN_RST = 19'h00000;
   // register byte offsets
   localparam logic [7:0] ADDR_MS_LEN = 8'h00;
   localparam logic [7:0] ADDR_SEC_LEN = 8'h04;
   localparam logic [7:0] ADDR_MIN_LEN = 8'h08;
   localparam logic [7:0] ADDR_OUT_STAT = 8'h0c;
   localparam logic [7:0] ADDR_IN_STAT = 8'h10;
   localparam logic [7:0] ADDR_OCT_BASE = 8'h20;
   // status field positions: [7:0] octal, then ms, sec, minute pairs
   localparam int unsigned NUM_OCT = 8;
   localparam int unsigned NUM_CH = 14;
   localparam int unsigned POS_MS = 8;
   localparam int unsigned POS_SEC = 10;
   localparam int unsigned POS_MIN = 12;
endpackage : pmp_pkg

// ---- design/pmp_tick.sv ----
// one millisecond enable pulse from the system clock
`timescale 1ns/1ps
`default_nettype none
module pmp_tick #(
   parameter int unsigned CYC = pmp_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // one cycle pulse every millisecond
   output logic tick
);
   logic [pmp_pkg::DIV_W-1:0] div_reg;

   // free running divider; tick comes from a flop so it is glitch free
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_reg <= '0;
         tick <= 1'b0;
      end else if (div_reg == pmp_pkg::DIV_W'(CYC - 1)) begin
         div_reg <= '0;
         tick <= 1'b1;
      end else begin
         div_reg <= div_reg + 1'b1;
         tick <= 1'b0;
      end
   end

   a_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
      tick |-> div_reg == '0) else $error("tick not aligned to divider wrap");
endmodule : pmp_tick
`default_nettype wire

// ---- design/pmp_chan.sv ----
// one stretching channel: output held for a millisecond count after a rising input
`timescale 1ns/1ps
`default_nettype none
module pmp_chan (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // millisecond enable
   input wire logic tick,
   // synchronised trigger and length in ms
   input wire logic trig,
   input wire logic [pmp_pkg::CNT_W-1:0] len_ms,
   // stretched output
   output logic pulse_out
);
   logic trig_d_reg;
   logic [pmp_pkg::CNT_W-1:0] cnt_reg;
   logic rise;

   assign rise = trig & ~trig_d_reg;

   // edge memory; a trigger high from reset counts as a rising edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         trig_d_reg <= 1'b0;
      end else begin
         trig_d_reg <= trig;
      end
   end

   // load on rising edge, count down on ticks; a retrigger restarts the length
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
      end else if (rise) begin
         cnt_reg <= len_ms;
      end else if (tick && cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // long input holds the output, short one is stretched; zero length just follows
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= trig | (cnt_reg != '0);
      end
   end

   a_rise_sets_out: assert property (@(posedge ref_clk) disable iff (rst)
      rise |=> pulse_out) else $error("output not set after rising input");
   a_load_length: assert property (@(posedge ref_clk) disable iff (rst)
      rise |=> cnt_reg == $past(len_ms)) else $error("length not loaded");
   a_count_down: assert property (@(posedge ref_clk) disable iff (rst)
      (tick && !rise && cnt_reg != '0) |=> cnt_reg == $past(cnt_reg) - 1'b1)
      else $error("countdown did not step");
   a_hold_while_in: assert property (@(posedge ref_clk) disable iff (rst)
      trig[*2] |-> pulse_out) else $error("output dropped while input high");
   a_zero_follows: assert property (@(posedge ref_clk) disable iff (rst)
      (len_ms == '0 && cnt_reg == '0 && !rise) |=> pulse_out == $past(trig))
      else $error("zero length does not follow input");
   a_drop_after: assert property (@(posedge ref_clk) disable iff (rst)
      (!trig && cnt_reg == '0) |=> !pulse_out) else $error("output stuck after expiry");
   c_short_stretched: cover property (@(posedge ref_clk) disable iff (rst)
      rise ##1 !trig ##1 (pulse_out && cnt_reg != '0));
   c_expiry: cover property (@(posedge ref_clk) disable iff (rst)
      (pulse_out && !trig && cnt_reg == 25'h1 && tick) ##2 !pulse_out);
endmodule : pmp_chan
`default_nettype wire

// ---- design/pmp_top.sv ----
// pulse stretcher group: three two-channel minimum pulse timers and one eight-channel timer
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Each two-channel timer has two channels that run independently of each other.
// - A rising two-channel input sets its output and holds it at least the set length.
// - Both channels of one two-channel timer use the one shared length register.
// - The millisecond timer length runs 0 to 60000 ms in 1 ms steps, reset value 150.
// - The seconds timer length runs 0 to 300 s in 1 s steps, reset value 0, for both channels.
// - The minutes timer length runs 0 to 300 min in 1 min steps, reset value 0, for both.
// - The octal timer has eight independent channels, one input and one output each.
// - Each octal channel has its own length, 0 to 3600000 ms in 10 ms steps, reset value 0.
// - A rising octal input sets its output for that channel's own length.
// - Octal pulse lengths are kept within 1 percent or 20 ms of the setting.
module pmp_top #(
   parameter int unsigned MS_CYCLES = pmp_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // millisecond timer pins
   input wire logic ms_trigger_input_a,
   input wire logic ms_trigger_input_b,
   output logic ms_stretched_output_a,
   output logic ms_stretched_output_b,
   // seconds timer pins
   input wire logic sec_trigger_input_a,
   input wire logic sec_trigger_input_b,
   output logic sec_stretched_output_a,
   output logic sec_stretched_output_b,
   // minutes timer pins
   input wire logic minute_trigger_input_a,
   input wire logic minute_trigger_input_b,
   output logic minute_stretched_output_a,
   output logic minute_stretched_output_b,
   // octal timer pins
   input wire logic [7:0] octal_trigger_in,
   output logic [7:0] pulse_output_ch
);
   localparam int unsigned NCH = pmp_pkg::NUM_CH;
   localparam int unsigned NOCT = pmp_pkg::NUM_OCT;

   logic [15:0] ms_len_reg;
   logic [8:0] sec_len_reg;
   logic [8:0] min_len_reg;
   logic [18:0] oct_len_reg [NOCT];
   logic [NCH-1:0] pin_raw;
   logic [NCH-1:0] sync1_reg;
   logic [NCH-1:0] sync2_reg;
   logic [NCH-1:0] out_vec;
   logic [pmp_pkg::CNT_W-1:0] len_ms [NCH];
   logic tick;
   logic ack_reg;
   logic req;
   logic wr_fire;
   logic oct_hit;
   logic [2:0] oct_idx;
   logic [31:0] rd_next;

   // merge a write into a register under the byte enables
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // out of range writes saturate at the top of the range rather than wrap
   function automatic logic [24:0] clamp(input logic [31:0] v, input logic [24:0] mx);
      clamp = (v > {7'h00, mx}) ? mx : v[24:0];
   endfunction : clamp

   // gather pins into one vector in status layout
   assign pin_raw = {minute_trigger_input_b, minute_trigger_input_a,
                     sec_trigger_input_b, sec_trigger_input_a,
                     ms_trigger_input_b, ms_trigger_input_a, octal_trigger_in};

   // two flop synchroniser; resets to false so an idle pin reads inactive
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   // shared millisecond time base
   pmp_tick #(
      .CYC(MS_CYCLES)
   ) u_tick (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(tick)
   );

   // lengths in ms: octal steps are 10 ms, pairs share one setting each
   always_comb begin
      for (int i = 0; i < NOCT; i++) begin
         len_ms[i] = 25'(oct_len_reg[i]) * pmp_pkg::OCT_STEP_MS;
      end
      len_ms[pmp_pkg::POS_MS] = 25'(ms_len_reg);
      len_ms[pmp_pkg::POS_MS+1] = 25'(ms_len_reg);
      len_ms[pmp_pkg::POS_SEC] = 25'(sec_len_reg) * pmp_pkg::MS_PER_S;
      len_ms[pmp_pkg::POS_SEC+1] = 25'(sec_len_reg) * pmp_pkg::MS_PER_S;
      len_ms[pmp_pkg::POS_MIN] = 25'(min_len_reg) * pmp_pkg::MS_PER_MIN;
      len_ms[pmp_pkg::POS_MIN+1] = 25'(min_len_reg) * pmp_pkg::MS_PER_MIN;
   end

   // one private counter per channel so no channel disturbs another
   for (genvar g = 0; g < NCH; g++) begin : g_chan
      pmp_chan u_chan (
         .ref_clk(ref_clk),
         .rst(rst),
         .tick(tick),
         .trig(sync2_reg[g]),
         .len_ms(len_ms[g]),
         .pulse_out(out_vec[g])
      );
   end

   // outputs straight from the channel flops
   assign pulse_output_ch = out_vec[NOCT-1:0];
   assign ms_stretched_output_a = out_vec[pmp_pkg::POS_MS];
   assign ms_stretched_output_b = out_vec[pmp_pkg::POS_MS+1];
   assign sec_stretched_output_a = out_vec[pmp_pkg::POS_SEC];
   assign sec_stretched_output_b = out_vec[pmp_pkg::POS_SEC+1];
   assign minute_stretched_output_a = out_vec[pmp_pkg::POS_MIN];
   assign minute_stretched_output_b = out_vec[pmp_pkg::POS_MIN+1];

   // bus handshake: every access waits exactly one cycle
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_reg;
   assign wr_fire = avs_write & ack_reg;
   assign oct_hit = (avs_address[7:5] == pmp_pkg::ADDR_OCT_BASE[7:5]);
   assign oct_idx = avs_address[4:2];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // length registers; writes saturate to the legal range
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ms_len_reg <= pmp_pkg::MS_LEN_RST;
         sec_len_reg <= pmp_pkg::SEC_LEN_RST;
         min_len_reg <= pmp_pkg::MIN_LEN_RST;
      end else if (wr_fire) begin
         unique case ({avs_address[7:2], 2'b00})
            pmp_pkg::ADDR_MS_LEN: begin
               ms_len_reg <= 16'(clamp(be_merge({16'h0000, ms_len_reg}, avs_writedata,
                                avs_byteenable), pmp_pkg::MS_LEN_MAX));
            end
            pmp_pkg::ADDR_SEC_LEN: begin
               sec_len_reg <= 9'(clamp(be_merge({23'h000000, sec_len_reg}, avs_writedata,
                                 avs_byteenable), pmp_pkg::SEC_LEN_MAX));
            end
            pmp_pkg::ADDR_MIN_LEN: begin
               min_len_reg <= 9'(clamp(be_merge({23'h000000, min_len_reg}, avs_writedata,
                                 avs_byteenable), pmp_pkg::MIN_LEN_MAX));
            end
            default: begin
            end
         endcase
      end
   end

   // per channel octal lengths, indexed by address
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NOCT; i++) begin
            oct_len_reg[i] <= pmp_pkg::OCT_LEN_RST;
         end
      end else if (wr_fire && oct_hit) begin
         oct_len_reg[oct_idx] <= 19'(clamp(be_merge({13'h0000, oct_len_reg[oct_idx]},
                                 avs_writedata, avs_byteenable), pmp_pkg::OCT_LEN_MAX));
      end
   end

   // read mux; unmapped words read zero
   always_comb begin
      rd_next = 32'h00000000;
      if (oct_hit) begin
         rd_next = {13'h0000, oct_len_reg[oct_idx]};
      end else begin
         unique case ({avs_address[7:2], 2'b00})
            pmp_pkg::ADDR_MS_LEN: rd_next = {16'h0000, ms_len_reg};
            pmp_pkg::ADDR_SEC_LEN: rd_next = {23'h000000, sec_len_reg};
            pmp_pkg::ADDR_MIN_LEN: rd_next = {23'h000000, min_len_reg};
            pmp_pkg::ADDR_OUT_STAT: rd_next = {18'h00000, out_vec};
            pmp_pkg::ADDR_IN_STAT: rd_next = {18'h00000, sync2_reg};
            default: rd_next = 32'h00000000;
         endcase
      end
   end

   // read data captured in the wait cycle so it stands when waitrequest drops
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_reg) begin
         avs_readdata <= rd_next;
      end
   end

   a_wait_one: assert property (@(posedge ref_clk) disable iff (rst)
      (req && avs_waitrequest) |=> !avs_waitrequest) else $error("access held too long");
   a_ms_range: assert property (@(posedge ref_clk) disable iff (rst)
      25'(ms_len_reg) <= pmp_pkg::MS_LEN_MAX) else $error("ms length out of range");
   a_sec_range: assert property (@(posedge ref_clk) disable iff (rst)
      25'(sec_len_reg) <= pmp_pkg::SEC_LEN_MAX) else $error("s length out of range");
   a_min_range: assert property (@(posedge ref_clk) disable iff (rst)
      25'(min_len_reg) <= pmp_pkg::MIN_LEN_MAX) else $error("min length out of range");
   a_oct_write: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_fire && oct_hit && avs_byteenable == 4'hf && avs_writedata <= 32'h00057e40)
      |=> oct_len_reg[$past(oct_idx)] == $past(avs_writedata[18:0]))
      else $error("octal length write lost");
   a_pair_shared: assert property (@(posedge ref_clk) disable iff (rst)
      len_ms[pmp_pkg::POS_SEC] == len_ms[pmp_pkg::POS_SEC+1]
      && len_ms[pmp_pkg::POS_MIN] == len_ms[pmp_pkg::POS_MIN+1]
      && len_ms[pmp_pkg::POS_MS] == len_ms[pmp_pkg::POS_MS+1])
      else $error("pair length mismatch");
   a_pin_to_out: assert property (@(posedge ref_clk) disable iff (rst)
      pin_raw[0][*3] |=> out_vec[0])
      else $error("octal pin did not reach output");
   c_bus_write: cover property (@(posedge ref_clk) disable iff (rst) wr_fire && oct_hit);
   c_bus_read: cover property (@(posedge ref_clk) disable iff (rst)
      avs_read && !avs_waitrequest && avs_address == pmp_pkg::ADDR_OUT_STAT);
endmodule : pmp_top
`default_nettype wire

// ---- bench/pmp_src.sv ----
// upstream logic model driving the fourteen trigger pins
`timescale 1ns/1ps
`default_nettype none
module pmp_src (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // requested trigger levels, status bit order
   input wire logic [13:0] go,
   // trigger pins
   output logic [13:0] trig
);
   // each pin moves on its own, launched just after an edge; idle pins sit false
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         trig <= 14'h0000;
      end else begin
         trig <= go;
      end
   end
endmodule : pmp_src
`default_nettype wire

// ---- bench/pmp_top_tb_top.sv ----
// self-checking bench for the pulse stretcher group
`timescale 1ns/1ps
`default_nettype none
module pmp_top_tb_top;
   // 10 cycles per ms keeps second-long pulses short
   localparam int unsigned MSC = 10;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h00000000;
   logic [3:0] be = 4'hf;
   logic [31:0] rdat;
   logic wreq;
   logic [13:0] go = 14'h0000;
   logic [13:0] trig;
   logic [13:0] outs;
   int bad_count = 0;
   int check_count = 0;
   int cyc = 0;
   int dur [14];
   // design under test
   pmp_top #(.MS_CYCLES(MSC)) pmp_top_i (
      .ref_clk(ref_clk), .rst(rst),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .ms_trigger_input_a(trig[8]), .ms_trigger_input_b(trig[9]),
      .ms_stretched_output_a(outs[8]), .ms_stretched_output_b(outs[9]),
      .sec_trigger_input_a(trig[10]), .sec_trigger_input_b(trig[11]),
      .sec_stretched_output_a(outs[10]), .sec_stretched_output_b(outs[11]),
      .minute_trigger_input_a(trig[12]), .minute_trigger_input_b(trig[13]),
      .minute_stretched_output_a(outs[12]), .minute_stretched_output_b(outs[13]),
      .octal_trigger_in(trig[7:0]), .pulse_output_ch(outs[7:0])
   );
   // upstream partner
   pmp_src pmp_src_i (.ref_clk(ref_clk), .rst(rst), .go(go), .trig(trig));
   // 25 mhz clock
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   // hang guard, well above the roughly 11300 cycles the run needs
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   // one avalon access; waitrequest and read data are taken as they stand at the rising edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge ref_clk);
      adr <= a;
      wr <= w;
      rd <= ~w;
      wdat <= d;
      // only the hang guard ends a wait that never finishes
      do begin
         @(posedge ref_clk);
      end while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask : wreg
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h00000000, q);
      check(what, q, exp);
   endtask : rchk
   // raise the masked triggers for hold cycles and count high cycles of every output
   task automatic fire(input logic [13:0] m, input int hold, input int win);
      for (int i = 0; i < 14; i++) dur[i] = 0;
      for (int k = 0; k < hold + win; k++) begin
         @(posedge ref_clk);
         if (k == 0) go <= m;
         if (k == hold) go <= 14'h0000;
         @(negedge ref_clk);
         for (int i = 0; i < 14; i++) if (outs[i] === 1'b1) dur[i]++;
      end
   endtask : fire
   function automatic logic inr(input int v, input int lo, input int hi);
      return (v >= lo) && (v <= hi);
   endfunction : inr
   // reset values of every length, and an unmapped place
   task automatic t_reset_vals();
      rchk("ms len", 8'h00, 32'h00000096);
      rchk("sec len", 8'h04, 32'h00000000);
      rchk("min len", 8'h08, 32'h00000000);
      for (int i = 0; i < 8; i++) rchk("oct len", 8'h20 + 8'(4 * i), 32'h00000000);
      rchk("unmapped", 8'h40, 32'h00000000);
   endtask : t_reset_vals
   // over-range writes clamp at the top of each range; byte lanes merge
   task automatic t_saturate();
      wreg(8'h00, 32'hffffffff);
      rchk("ms max", 8'h00, 32'h0000ea60);
      wreg(8'h04, 32'hffffffff);
      rchk("sec max", 8'h04, 32'h0000012c);
      wreg(8'h08, 32'hffffffff);
      rchk("min max", 8'h08, 32'h0000012c);
      wreg(8'h3c, 32'hffffffff);
      rchk("oct max", 8'h3c, 32'h00057e40);
      be <= 4'h1;
      wreg(8'h00, 32'h00000012);
      be <= 4'hf;
      rchk("ms lane", 8'h00, 32'h0000ea12);
      wreg(8'h0c, 32'hffffffff);
      rchk("status ro", 8'h0c, 32'h00000000);
   endtask : t_saturate
   // both ms channels share one length; a long input holds, the other stays quiet
   task automatic t_ms_pair();
      wreg(8'h00, 32'h00000005);
      fire(14'h0300, 2, 80);
      check("ms a short", inr(dur[8], 40, 60), 1'b1);
      check("ms b short", inr(dur[9], 40, 60), 1'b1);
      fire(14'h0100, 100, 40);
      check("ms a long", inr(dur[8], 100, 112), 1'b1);
      check("ms b idle", dur[9], 32'h00000000);
   endtask : t_ms_pair
   // eight channels, each with its own length in 10 ms steps
   task automatic t_octal();
      for (int i = 0; i < 8; i++) wreg(8'h20 + 8'(4 * i), 32'(i + 1));
      fire(14'h00ff, 2, 850);
      for (int i = 0; i < 8; i++) begin
         check("oct dur", inr(dur[i], (i + 1) * 100 - 10, (i + 1) * 100 + 10), 1'b1);
      end
      check("oct quiet", dur[8], 32'h00000000);
      check("oct ch7", inr(dur[7], 790, 810), 1'b1);
   endtask : t_octal
   // zero length follows the input; one second stretches to 1000 ms
   task automatic t_zero_and_sec();
      wreg(8'h04, 32'h00000000);
      wreg(8'h08, 32'h00000000);
      wreg(8'h20, 32'h00000000);
      // both status words show a held input on zero-length channels
      go <= 14'h2001;
      repeat (4) @(posedge ref_clk);
      rchk("in stat", 8'h10, 32'h00002001);
      rchk("out stat", 8'h0c, 32'h00002001);
      go <= 14'h0000;
      repeat (4) @(posedge ref_clk);
      rchk("out clear", 8'h0c, 32'h00000000);
      fire(14'h3c01, 20, 20);
      check("oct zero", inr(dur[0], 20, 21), 1'b1);
      check("sec zero", inr(dur[10], 20, 21), 1'b1);
      check("min zero", inr(dur[13], 20, 21), 1'b1);
      wreg(8'h04, 32'h00000001);
      fire(14'h0c00, 2, 10020);
      check("sec a 1s", inr(dur[10], 9990, 10010), 1'b1);
      check("sec b 1s", inr(dur[11], 9990, 10010), 1'b1);
   endtask : t_zero_and_sec
   // main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      check("idle out", outs, 14'h0000);
      t_reset_vals();
      t_saturate();
      t_ms_pair();
      t_octal();
      t_zero_and_sec();
      wrap_up();
   end
endmodule : pmp_top_tb_top
`default_nettype wire
